/* dac_load_defines.svh */
`ifndef DAC_LOAD_DEFINES_SVH
`define DAC_LOAD_DEFINES_SVH
// Summary of operation
// - frame sync low enables serial shifting
// - sample one bit per falling edge, 32
// - early frame sync rise discards partial write
// - 32-bit shift register, falling-edge data capture
// - load strobe low: update at 32nd edge
// - load strobe high: input register only, defer
// - load strobe fall updates all channels together
// - clear input acts on its falling edge
// - clear held low ignores load strobe pulses
// - clear loads input and dac from clear code
// - clear code defaults to zero scale
// - power-on level pin picks zero or midscale
// - frame: 4 spare, cmd, addr, code, 4 spare
`define FRAME_BITS      6'd32
`define CMD_MSB         27
`define CMD_LSB         24
`define ADDR_MSB        23
`define ADDR_LSB        20
`define CODE_MSB        19
`define CODE_LSB        4
`define NUM_CH          4
`define CODE_ZERO       16'h0000
`define CODE_MID        16'h8000
`define CODE_FULL       16'hFFFF
`define ADDR_ALL        4'hF
`define FIFO_DEPTH      32
`define FIFO_AW         5
`endif

/* dac_load_pkg.sv */
package dac_load_pkg;
    // one captured serial frame
    typedef struct packed {
        logic [3:0]  cmd;
        logic [3:0]  addr;
        logic [15:0] code;
        logic        load_now;
    } frame_s;
    // clear code selection
    typedef enum logic [1:0] {
        CLR_ZERO = 2'h0,
        CLR_MID  = 2'h1,
        CLR_FULL = 2'h2
    } clr_sel_e;
    typedef enum logic [2:0] {
        LNK_IDLE = 3'b001,
        LNK_SHIFT = 3'b010,
        LNK_DONE = 3'b100
    } link_state_e;
endpackage

/* frame_fifo.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// frame fifo: single clock, registered read data
// ------------------------------------------------------------
module frame_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_sys_rst,
    input  wire logic             i_ce,
    // write side
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    input  wire logic [WIDTH-1:0] i_wr_data,
    // read side
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic [WIDTH-1:0]      o_rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];        // storage
    logic [AW:0]      wp_ff, nxt_wp;      // write pointer
    logic [AW:0]      rp_ff, nxt_rp;      // read pointer
    logic             full, empty;
    logic             do_wr, do_rd;

    assign full       = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    assign empty      = (wp_ff == rp_ff);
    assign o_wr_ready = !full;
    assign do_wr      = i_ce && i_wr_valid && !full;
    // output register holds head when valid
    assign do_rd      = i_ce && !empty && (!o_rd_valid || i_rd_ready);

    // next pointers
    always_comb begin
        nxt_wp = wp_ff + (AW+1)'(do_wr);
        nxt_rp = rp_ff + (AW+1)'(do_rd);
    end

    // pointer and valid registers
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wp_ff      <= '0;
            rp_ff      <= '0;
            o_rd_valid <= 1'b0;
        end else if (i_ce) begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            if (do_rd)
                o_rd_valid <= 1'b1;
            else if (i_rd_ready)
                o_rd_valid <= 1'b0;
        end
    end

    // memory and read data, no reset needed for storage
    always_ff @(posedge i_clock) begin
        if (do_wr)
            mem[wp_ff[AW-1:0]] <= i_wr_data;
        if (do_rd)
            o_rd_data <= mem[rp_ff[AW-1:0]];
    end
endmodule

/* quad_dac_serial_load_ctrl.sv */
`timescale 1ns/1ps
`include "dac_load_defines.svh"
module quad_dac_serial_load_ctrl
    import dac_load_pkg::*;
(
    // system clock domain
    input  wire logic          i_clock,
    input  wire logic          i_sys_rst,
    input  wire logic          i_ce,
    // serial link, serial clock is its own domain
    input  wire logic          i_sclk,
    input  wire logic          i_sync_n,
    input  wire logic          i_din,
    // control pins
    input  wire logic          i_load_strobe_n,
    input  wire logic          i_async_clear_n,
    input  wire logic          i_por_mid,
    input  wire logic [1:0]    i_clear_code_sel,
    // dac outputs
    output logic [15:0]        o_dac_code [`NUM_CH],
    output logic [15:0]        o_input_code [`NUM_CH],
    output logic               o_frame_drop
);
    // ------------------------------------------------------------
    // link domain: shift on falling serial clock
    // ------------------------------------------------------------
    logic [31:0]  shreg_ff, nxt_shreg;     // input shift register
    logic [5:0]   bitcnt_ff, nxt_bitcnt;   // bits taken in this frame
    logic         tog_ff, nxt_tog;         // frame-done toggle
    logic [24:0]  hold_ff, nxt_hold;       // captured frame, stable across crossing
    logic         ld_now;                  // load strobe seen low at last edge

    // frame sync high resets the shift register and bit count asynchronously; this both
    // aborts short frames and rearms after a full one
    always_comb begin
        nxt_shreg  = shreg_ff;
        nxt_bitcnt = bitcnt_ff;
        nxt_tog    = tog_ff;
        nxt_hold   = hold_ff;
        ld_now     = !i_load_strobe_n;
        if (bitcnt_ff < `FRAME_BITS) begin
            nxt_shreg  = {shreg_ff[30:0], i_din};
            nxt_bitcnt = bitcnt_ff + 6'd1;
            if (bitcnt_ff == `FRAME_BITS - 6'd1) begin
                nxt_tog  = !tog_ff;
                // the 32nd bit is still on the data line, so every field
                // sits one place lower in the shift register
                nxt_hold = {shreg_ff[`CMD_MSB-1:`CMD_LSB-1],
                            shreg_ff[`ADDR_MSB-1:`ADDR_LSB-1],
                            shreg_ff[`CODE_MSB-1:`CODE_LSB-1], ld_now};
            end
        end
    end

    // link registers; toggle and hold survive frame sync high
    always_ff @(negedge i_sclk or posedge i_sync_n) begin
        if (i_sync_n) begin
            shreg_ff  <= 32'h0000_0000;
            bitcnt_ff <= 6'h00;
        end else begin
            shreg_ff  <= nxt_shreg;
            bitcnt_ff <= nxt_bitcnt;
        end
    end

    always_ff @(negedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tog_ff  <= 1'b0;
            hold_ff <= '0;
        end else if (!i_sync_n) begin
            tog_ff  <= nxt_tog;
            hold_ff <= nxt_hold;
        end
    end

    // ------------------------------------------------------------
    // crossing and pin synchronisers into system clock
    // ------------------------------------------------------------
    logic [2:0] tog_s_ff;      // toggle sync plus edge stage
    logic [2:0] ld_s_ff;       // load strobe sync plus edge stage
    logic [2:0] clr_s_ff;      // clear sync plus edge stage
    logic [1:0] por_s_ff;      // power-on level sync
    logic [1:0] sel_s0_ff, sel_s1_ff;

    // two flops before any logic reads a pin; stage 0 only feeds stage 1
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tog_s_ff   <= 3'h0;
            ld_s_ff    <= 3'h7;
            clr_s_ff   <= 3'h7;
            por_s_ff   <= 2'h0;
            sel_s0_ff  <= 2'h0;
            sel_s1_ff  <= 2'h0;
        end else if (i_ce) begin
            tog_s_ff   <= {tog_s_ff[1:0], tog_ff};
            ld_s_ff    <= {ld_s_ff[1:0], i_load_strobe_n};
            clr_s_ff   <= {clr_s_ff[1:0], i_async_clear_n};
            por_s_ff   <= {por_s_ff[0], i_por_mid};
            sel_s0_ff  <= i_clear_code_sel;
            sel_s1_ff  <= sel_s0_ff;
        end
    end

    logic frame_evt, ld_fall, clr_fall, clr_low;
    assign frame_evt = tog_s_ff[2] ^ tog_s_ff[1];
    assign ld_fall   = ld_s_ff[2] & !ld_s_ff[1];
    assign clr_fall  = clr_s_ff[2] & !clr_s_ff[1];
    assign clr_low   = !clr_s_ff[1];

    // ------------------------------------------------------------
    // frame fifo between crossing and register update
    // ------------------------------------------------------------
    frame_s     fifo_out;
    logic       fifo_valid, fifo_wr_ready;
    logic [24:0] fifo_rd_data;
    assign fifo_out = frame_s'(fifo_rd_data);

    frame_fifo #(
        .WIDTH (25),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .i_clock    (i_clock),
        .i_sys_rst  (i_sys_rst),
        .i_ce       (i_ce),
        .i_wr_valid (frame_evt),
        .o_wr_ready (fifo_wr_ready),
        .i_wr_data  (hold_ff),
        .o_rd_valid (fifo_valid),
        .i_rd_ready (!clr_low),
        .o_rd_data  (fifo_rd_data)
    );

    // ------------------------------------------------------------
    // input and dac registers
    // ------------------------------------------------------------
    logic [15:0] inreg_ff [`NUM_CH];
    logic [15:0] nxt_inreg [`NUM_CH];
    logic [15:0] dacreg_ff [`NUM_CH];
    logic [15:0] nxt_dacreg [`NUM_CH];
    logic        por_done_ff, nxt_por_done;    // power-on level applied once
    logic [1:0]  por_arm_ff, nxt_por_arm;      // waits out the strap synchroniser
    logic        drop_ff, nxt_drop;

    // clear code lookup
    function automatic logic [15:0] clear_code(input logic [1:0] sel);
        case (sel)
            CLR_MID:  clear_code = `CODE_MID;
            CLR_FULL: clear_code = `CODE_FULL;
            default:  clear_code = `CODE_ZERO;
        endcase
    endfunction

    // channel select, all-channel address hits every one
    function automatic logic ch_hit(input logic [3:0] a, input int ch);
        ch_hit = (a == `ADDR_ALL) || (a == 4'(ch));
    endfunction

    always_comb begin
        // strap is only trusted once both synchroniser stages hold the pin
        nxt_por_arm  = {por_arm_ff[0], 1'b1};
        nxt_por_done = por_arm_ff[1];
        nxt_drop     = frame_evt && !fifo_wr_ready;
        for (int c = 0; c < `NUM_CH; c++) begin
            nxt_inreg[c]  = inreg_ff[c];
            nxt_dacreg[c] = dacreg_ff[c];
            if (!por_done_ff) begin
                // strap caught after reset release
                nxt_inreg[c]  = por_s_ff[1] ? `CODE_MID : `CODE_ZERO;
                nxt_dacreg[c] = por_s_ff[1] ? `CODE_MID : `CODE_ZERO;
            end else if (clr_fall) begin
                nxt_inreg[c]  = clear_code(sel_s1_ff);
                nxt_dacreg[c] = clear_code(sel_s1_ff);
            end else if (!clr_low) begin
                if (fifo_valid && ch_hit(fifo_out.addr, c)) begin
                    nxt_inreg[c] = fifo_out.code;
                    if (fifo_out.load_now)
                        nxt_dacreg[c] = fifo_out.code;
                end
                if (ld_fall)
                    nxt_dacreg[c] = nxt_inreg[c];
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            por_done_ff <= 1'b0;
            por_arm_ff  <= 2'h0;
            drop_ff     <= 1'b0;
            for (int c = 0; c < `NUM_CH; c++) begin
                inreg_ff[c]  <= 16'h0000;
                dacreg_ff[c] <= 16'h0000;
            end
        end else if (i_ce) begin
            por_done_ff <= nxt_por_done;
            por_arm_ff  <= nxt_por_arm;
            drop_ff     <= nxt_drop;
            for (int c = 0; c < `NUM_CH; c++) begin
                inreg_ff[c]  <= nxt_inreg[c];
                dacreg_ff[c] <= nxt_dacreg[c];
            end
        end
    end

    assign o_dac_code   = dacreg_ff;
    assign o_input_code = inreg_ff;
    assign o_frame_drop = drop_ff;
endmodule

/* quad_dac_serial_load_ctrl_checker.sv */
`timescale 1ns/1ps
module quad_dac_serial_load_ctrl_checker (
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    // control pins
    input wire logic        i_sync_n,
    input wire logic        i_load_strobe_n,
    input wire logic        i_async_clear_n,
    input wire logic        i_por_mid,
    input wire logic [1:0]  i_clear_code_sel,
    // register views
    input wire logic [15:0] o_dac_code [4],
    input wire logic [15:0] o_input_code [4]
);
    // ------------------------------------------------------------
    // packed views, clear value and quiet-time counter
    // ------------------------------------------------------------
    wire logic [63:0] dac_all = {o_dac_code[3], o_dac_code[2], o_dac_code[1], o_dac_code[0]};
    wire logic [63:0] in_all  = {o_input_code[3], o_input_code[2], o_input_code[1], o_input_code[0]};
    logic [15:0]      clr_val;    // code a clear must load
    logic [3:0]       quiet_ff;   // cycles with no frame, load or clear
    logic [3:0]       nxt_quiet;
    // saturating count, so a long idle time never wraps into a false window
    always_comb begin
        clr_val = (i_clear_code_sel == 2'h1) ? 16'h8000 :
                  (i_clear_code_sel == 2'h2) ? 16'hffff : 16'h0000;
        nxt_quiet = (quiet_ff == 4'hf) ? 4'hf : quiet_ff + 4'h1;
        if (!(i_sync_n && i_load_strobe_n && i_async_clear_n)) begin
            nxt_quiet = 4'h0;
        end
    end
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            quiet_ff <= 4'h0;
        end else begin
            quiet_ff <= nxt_quiet;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // load and clear both idle
    sequence s_held;
        i_load_strobe_n && i_async_clear_n;
    endsequence
    a_strap_dac_value: assert property ($fell(i_sys_rst) |-> ##[0:4]
        dac_all == (i_por_mid ? {4{16'h8000}} : 64'h0)) else $error("dac strap wrong");
    a_strap_input_value: assert property ($fell(i_sys_rst) |-> ##[0:4]
        in_all == (i_por_mid ? {4{16'h8000}} : 64'h0)) else $error("input strap wrong");
    a_clear_dac_code: assert property ($fell(i_async_clear_n) |-> ##[1:8]
        dac_all == {4{clr_val}}) else $error("clear missed dac");
    a_clear_input_code: assert property ($fell(i_async_clear_n) |-> ##[1:8]
        in_all == {4{clr_val}}) else $error("clear missed input");
    a_clear_blocks_load: assert property (!i_async_clear_n [*8] |=> $stable(dac_all))
        else $error("dac moved under clear");
    a_load_fall_all: assert property ($fell(i_load_strobe_n) && i_async_clear_n && i_sync_n
        |-> ##[1:8] dac_all == in_all) else $error("load fall not applied");
    a_load_high_hold: assert property (s_held [*8] |=> $stable(dac_all))
        else $error("dac moved with load high");
    a_quiet_input_hold: assert property (quiet_ff == 4'hf |-> $stable(in_all))
        else $error("input moved while idle");
endmodule
bind quad_dac_serial_load_ctrl quad_dac_serial_load_ctrl_checker i_quad_dac_serial_load_ctrl_checker (
    .i_clock, .i_sys_rst, .i_sync_n, .i_load_strobe_n, .i_async_clear_n,
    .i_por_mid, .i_clear_code_sel, .o_dac_code, .o_input_code);

/* host_serial_model.sv */
`timescale 1ns/1ps
module host_serial_model (
    // serial link driven by the host
    output logic o_sclk,
    output logic o_sync_n,
    output logic o_din
);
    // ------------------------------------------------------------
    // host port: clock idles high and stands still between frames
    // ------------------------------------------------------------
    initial begin
        o_sclk = 1'b1;
        o_sync_n = 1'b1;
        o_din = 1'b0;
    end
    // msb first, 30 ns clock; fewer than 32 bits aborts, more adds spare edges
    task automatic send(input logic [31:0] word, input int nbits);
        o_sync_n = 1'b0;
        #2;
        for (int i = 0; i < nbits; i++) begin
            o_din = (i < 32) ? word[31-i] : ~o_din;
            #15 o_sclk = 1'b0;
            #15 o_sclk = 1'b1;
        end
        #10 o_sync_n = 1'b1;
        o_din = ~o_din;  // released line must not keep its last bit
        #40;
    endtask
endmodule

/* quad_dac_serial_load_ctrl_tb.sv */
`timescale 1ns/1ps
module quad_dac_serial_load_ctrl_tb;
    // ------------------------------------------------------------
    // stimulus, observation and bookkeeping
    // ------------------------------------------------------------
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        load_strobe_n = 1'b1;
    logic        async_clear_n = 1'b1;
    logic        por_mid = 1'b0;
    logic [1:0]  clear_code_sel = 2'h0;
    logic        sclk;
    logic        sync_n;
    logic        din;
    logic [15:0] dac_code [4];
    logic [15:0] input_code [4];
    logic [15:0] clr_tab [4] = '{16'h0000, 16'h8000, 16'hffff, 16'h0000};
    int          fails = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    always #2 clock = ~clock;
    quad_dac_serial_load_ctrl i_quad_dac_serial_load_ctrl (
        .i_clock(clock), .i_sys_rst(sys_rst), .i_ce(1'b1), .i_sclk(sclk),
        .i_sync_n(sync_n), .i_din(din), .i_load_strobe_n(load_strobe_n),
        .i_async_clear_n(async_clear_n), .i_por_mid(por_mid),
        .i_clear_code_sel(clear_code_sel), .o_dac_code(dac_code),
        .o_input_code(input_code), .o_frame_drop());
    host_serial_model i_host_serial_model (.o_sclk(sclk), .o_sync_n(sync_n), .o_din(din));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic end_sim();
        if (fails == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // frames finish well before this; a hang ends the run here
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            end_sim();
        end
    end
    task automatic waitc(input int n);
        repeat (n) @(negedge clock);
    endtask
    function automatic logic [31:0] word(input logic [3:0] a, input logic [15:0] c);
        return {8'h03, a, c, 4'h0};
    endfunction
    task automatic t_strap(input logic mid);
        por_mid = mid;
        sys_rst = 1'b1;
        waitc(8);
        sys_rst = 1'b0;
        waitc(4);
        for (int k = 0; k < 4; k++) begin
            chk("dac strap", mid ? 16'h8000 : 16'h0000, dac_code[k]);
            chk("input strap", mid ? 16'h8000 : 16'h0000, input_code[k]);
        end
    endtask
    task automatic t_direct();
        load_strobe_n = 1'b0;
        i_host_serial_model.send(word(4'h1, 16'ha5c3), 32);
        waitc(12);
        chk("dac1", 16'ha5c3, dac_code[1]);
        chk("input1", 16'ha5c3, input_code[1]);
        chk("dac0", 16'h8000, dac_code[0]);
    endtask
    task automatic t_deferred();
        load_strobe_n = 1'b1;
        i_host_serial_model.send(word(4'hf, 16'h0f0f), 32);
        i_host_serial_model.send(word(4'h2, 16'h1234), 32);
        waitc(12);
        for (int k = 0; k < 4; k++) begin
            chk("input", (k == 2) ? 16'h1234 : 16'h0f0f, input_code[k]);
            chk("dac held", (k == 1) ? 16'ha5c3 : 16'h8000, dac_code[k]);
        end
        load_strobe_n = 1'b0;
        waitc(6);
        load_strobe_n = 1'b1;
        waitc(12);
        for (int k = 0; k < 4; k++) begin
            chk("dac loaded", (k == 2) ? 16'h1234 : 16'h0f0f, dac_code[k]);
        end
    endtask
    // a cut frame, then one with two spare edges after the 32nd
    task automatic t_abort_extra();
        load_strobe_n = 1'b0;
        i_host_serial_model.send(word(4'h0, 16'hffff), 20);
        waitc(12);
        chk("dac0 abort", 16'h0f0f, dac_code[0]);
        i_host_serial_model.send(word(4'h0, 16'h4321), 34);
        waitc(12);
        chk("dac0 extra", 16'h4321, dac_code[0]);
    endtask
    task automatic t_clear();
        load_strobe_n = 1'b1;
        for (int s = 0; s < 4; s++) begin
            clear_code_sel = s[1:0];
            waitc(10);
            async_clear_n = 1'b0;
            waitc(10);
            // frame under clear must wait in the queue, so a load pulse
            // that slipped through would copy input3, still holding the clear code, into dac3
            i_host_serial_model.send(word(4'h3, 16'h7777), 32);
            waitc(10);
            load_strobe_n = 1'b0;  // pulse that the clear must swallow
            waitc(6);
            load_strobe_n = 1'b1;
            waitc(4);
            chk("dac under clear", clr_tab[s], dac_code[3]);
            chk("input under clear", clr_tab[s], input_code[3]);
            async_clear_n = 1'b1;
            waitc(12);
            for (int k = 0; k < 4; k++) begin
                chk("dac clear", clr_tab[s], dac_code[k]);
                chk("input clear", (k == 3) ? 16'h7777 : clr_tab[s], input_code[k]);
            end
        end
    endtask
    initial begin
        @(negedge clock);
        t_strap(1'b0);
        t_strap(1'b1);
        t_direct();
        t_deferred();
        t_abort_extra();
        t_clear();
        end_sim();
    end
endmodule
